// ===== hdl/afac_pkg.sv
// constants for the audio format and silence configuration bank
package afac_pkg;
    // register offsets on the control port
    localparam logic [7:0] AFAC_OFS_FORMAT    = 8'h02;
    localparam logic [7:0] AFAC_OFS_RSVD3     = 8'h03;
    localparam logic [7:0] AFAC_OFS_DURATION  = 8'h04;
    localparam logic [7:0] AFAC_OFS_THRESHOLD = 8'h05;
    localparam logic [7:0] AFAC_OFS_EMPHRAMP  = 8'h06;
    // reset values
    localparam logic [7:0] AFAC_RST_FORMAT    = 8'h3c;
    localparam logic [7:0] AFAC_RST_RSVD3     = 8'h00;
    localparam logic [7:0] AFAC_RST_DURATION  = 8'h00;
    localparam logic [6:0] AFAC_RST_THRESHOLD = 7'h68;
    localparam logic [7:0] AFAC_RST_EMPHRAMP  = 8'h4a;
    // field positions, format register
    localparam int AFAC_ACT_LSB   = 6;
    localparam int AFAC_WBITS_LSB = 4;
    localparam int AFAC_BCLK_LSB  = 2;
    localparam int AFAC_JUST_LSB  = 0;
    // field positions, emphasis and ramp register
    localparam int AFAC_AUTOEMPH_BIT = 7;
    localparam int AFAC_BYPASS_BIT   = 6;
    localparam int AFAC_CURVE_LSB    = 4;
    localparam int AFAC_KEEP1_BIT    = 3;
    localparam int AFAC_RATE_LSB     = 0;
    // silence length numerator, in samples times duration value
    localparam logic [21:0] AFAC_SILENCE_NUM = 22'h1fff00;
    // volume ramp: one dB step per this many accumulated units
    localparam logic [10:0] AFAC_RAMP_DIV    = 11'h200;
    // word length codes, in bits
    localparam logic [5:0] AFAC_LEN32 = 6'h20;
    localparam logic [5:0] AFAC_LEN24 = 6'h18;
    localparam logic [5:0] AFAC_LEN16 = 6'h10;

    typedef enum logic [2:0] {
        AFAC_FRAME_I2S   = 3'b001,
        AFAC_FRAME_LEFT  = 3'b010,
        AFAC_FRAME_RIGHT = 3'b100
    } afac_frame_t;

    typedef enum logic [2:0] {
        AFAC_CURVE_32K  = 3'b001,
        AFAC_CURVE_44K  = 3'b010,
        AFAC_CURVE_48K  = 3'b100
    } afac_curve_t;
endpackage

// ===== hdl/afac_silence_if.sv
// signals between the register bank and the silence detector
`timescale 1ns/1ps
`default_nettype none
interface afac_silence_if;
    logic [7:0] durationVal;  // samples-per-flag divisor, zero disables
    logic [6:0] thresholdVal; // level in dB below full scale
    logic       clearAll;     // soft reset
    logic       silence;      // silence condition flagged

    modport cfg (output durationVal, output thresholdVal, output clearAll, input silence);
    modport det (input durationVal, input thresholdVal, input clearAll, output silence);
endinterface
`default_nettype wire

// ===== hdl/afac_silence_det.sv
// silence detector: level below threshold held for the programmed duration
`timescale 1ns/1ps
`default_nettype none
module afac_silence_det
    import afac_pkg::*;
(
    input  wire logic       clk,         // system clock
    input  wire logic       rst,         // async reset, active high
    input  wire logic       sampleTick,  // one pulse per audio sample
    input  wire logic [6:0] levelDb,     // audio level, dB below full scale
    afac_silence_if.det     bus          // settings and result
);
    logic [21:0] acc_q;
    logic [22:0] accSum;
    logic        below;

    // audio is at or quieter than the threshold
    assign below  = levelDb >= bus.thresholdVal;
    assign accSum = {1'b0, acc_q} + {15'h0000, bus.durationVal};

    ////////////////////////////////////////////////////////////////////////
    // each quiet sample adds the duration value; flag once the sum reaches
    // the numerator, i.e. after numerator / duration samples
    // (RULE5) duration count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= 22'h000000;
        end else if (bus.clearAll || !below || bus.durationVal == 8'h00) begin
            acc_q <= 22'h000000;
        end else if (sampleTick && acc_q < AFAC_SILENCE_NUM) begin
            acc_q <= (accSum[21:0] > AFAC_SILENCE_NUM) ? AFAC_SILENCE_NUM : accSum[21:0];
        end
    end

    // (RULE8) both conditions together
    // (RULE6) zero duration never flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.silence <= 1'b0;
        end else begin
            bus.silence <= !bus.clearAll && below && bus.durationVal != 8'h00
                           && acc_q >= AFAC_SILENCE_NUM;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/afac_cfg_bank.sv
// audio format, silence and emphasis configuration register bank
// What this block does
// (RULE1) action select: mute, ramp, both, none
// (RULE2) word width select: 32, 24, 16
// (RULE3) bit clocks per word: 32, 24, 16
// (RULE4) framing: right, left, or I2S default
// (RULE5) silence after numerator over duration samples
// (RULE6) zero duration disables silence detection
// (RULE7) seven-bit threshold in dB, default 104
// (RULE8) silence needs quiet level and duration
// (RULE9) auto emphasis from valid SPDIF status
// (RULE10) bypass bit set disables emphasis filters; auto emphasis on valid SPDIF status overrides the bypass bit
// (RULE11) curve select 32k, 44.1k, 48k
// (RULE12) software keeps bit three set
// (RULE13) ramp rate two-to-select times rate/512
// (RULE14) all fields return to defaults on resets
`timescale 1ns/1ps
`default_nettype none
module afac_cfg_bank
    import afac_pkg::*;
(
    input  wire logic        clk,            // system clock, 20 MHz
    input  wire logic        rst,            // async reset, active high
    input  wire logic        softReset,      // software reset pulse
    input  wire logic [7:0]  regAddr,        // control port register address
    input  wire logic [7:0]  regWrData,      // control port write byte
    input  wire logic        regWrEn,        // control port write strobe
    output logic      [7:0]  regRdData,      // read byte, one cycle after address
    input  wire logic        sampleTick,     // one pulse per audio sample
    input  wire logic [6:0]  levelDb,        // audio level, dB below full scale
    input  wire logic        spdifActive,    // input decoder is on SPDIF
    input  wire logic        csEmphValid,    // channel status carries emphasis
    input  wire logic [1:0]  csEmphSel,      // curve from channel status
    output logic      [5:0]  wordBits,       // serial data word length
    output logic      [5:0]  bclkPerWord,    // bit clocks per word
    output afac_frame_t      frameMode,      // serial framing
    output logic             silenceFlag,    // silence condition
    output logic             muteReq,        // mute requested by silence
    output logic             rampReq,        // ramp to ground requested
    output logic             emphEnable,     // de-emphasis filter engaged
    output afac_curve_t      emphCurve,      // de-emphasis curve in use
    output logic             rampStep        // one dB volume step pulse
);
    logic [7:0] format_q;
    logic [7:0] duration_q;
    logic [6:0] threshold_q;
    logic [7:0] emphRamp_q;
    logic [10:0] rampAcc_q;
    logic [10:0] rampSum;

    // link to the detector; its flag arrives one clock after
    // the accumulator saturates
    afac_silence_if sil ();

    ////////////////////////////////////////////////////////////////////////
    // register writes; reserved offset 3 ignores writes
    // soft reset outranks a write in the same cycle, so a
    // configuration byte racing a reset is dropped
    // (RULE14) defaults on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            format_q    <= AFAC_RST_FORMAT;
            duration_q  <= AFAC_RST_DURATION;
            threshold_q <= AFAC_RST_THRESHOLD;
            emphRamp_q  <= AFAC_RST_EMPHRAMP;
        end else if (softReset) begin
            format_q    <= AFAC_RST_FORMAT;
            duration_q  <= AFAC_RST_DURATION;
            threshold_q <= AFAC_RST_THRESHOLD;
            emphRamp_q  <= AFAC_RST_EMPHRAMP;
        end else if (regWrEn) begin
            if (regAddr == AFAC_OFS_FORMAT) begin
                format_q <= regWrData;
            end else if (regAddr == AFAC_OFS_DURATION) begin
                duration_q <= regWrData;
            end else if (regAddr == AFAC_OFS_THRESHOLD) begin
                // (RULE7) threshold field
                threshold_q <= regWrData[6:0];
            end else if (regAddr == AFAC_OFS_EMPHRAMP) begin
                // (RULE12) bit three stored as written
                emphRamp_q <= regWrData;
            end
        end
    end

    // registered read-back; unmapped and reserved offsets read zero
    // read data lags the address by one clock; a read in the cycle
    // of a write to the same offset returns the old byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regAddr == AFAC_OFS_FORMAT) begin
            regRdData <= format_q;
        end else if (regAddr == AFAC_OFS_RSVD3) begin
            regRdData <= AFAC_RST_RSVD3;
        end else if (regAddr == AFAC_OFS_DURATION) begin
            regRdData <= duration_q;
        end else if (regAddr == AFAC_OFS_THRESHOLD) begin
            regRdData <= {1'b0, threshold_q};
        end else if (regAddr == AFAC_OFS_EMPHRAMP) begin
            regRdData <= emphRamp_q;
        end else begin
            regRdData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial format decode
    // outputs change one clock after a write; the serial front end
    // should only pick them up between frames
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wordBits    <= AFAC_LEN32;
            bclkPerWord <= AFAC_LEN32;
            frameMode   <= AFAC_FRAME_I2S;
        end else begin
            // (RULE2) word width
            case (format_q[AFAC_WBITS_LSB +: 2])
                2'b00:   wordBits <= AFAC_LEN16;
                2'b01:   wordBits <= AFAC_LEN24;
                default: wordBits <= AFAC_LEN32;
            endcase
            // (RULE3) bit clocks per word
            case (format_q[AFAC_BCLK_LSB +: 2])
                2'b00:   bclkPerWord <= AFAC_LEN16;
                2'b01:   bclkPerWord <= AFAC_LEN24;
                default: bclkPerWord <= AFAC_LEN32;
            endcase
            // (RULE4) framing decode
            case (format_q[AFAC_JUST_LSB +: 2])
                2'b00:   frameMode <= AFAC_FRAME_I2S;
                2'b01:   frameMode <= AFAC_FRAME_LEFT;
                default: frameMode <= AFAC_FRAME_RIGHT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // silence detector hookup
    // soft reset also empties the accumulator, so a stale quiet
    // count cannot flag right after defaults return
    assign sil.durationVal  = duration_q;
    assign sil.thresholdVal = threshold_q;
    assign sil.clearAll     = softReset;

    afac_silence_det u_det (
        .clk        (clk),
        .rst        (rst),
        .sampleTick (sampleTick),
        .levelDb    (levelDb),
        .bus        (sil)
    );

    // action bits are read fresh each clock: rewriting them while
    // silence stands changes the requests one clock later
    // (RULE1) silence action
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            silenceFlag <= 1'b0;
            muteReq     <= 1'b0;
            rampReq     <= 1'b0;
        end else begin
            silenceFlag <= sil.silence;
            muteReq     <= sil.silence && format_q[AFAC_ACT_LSB];
            rampReq     <= sil.silence && format_q[AFAC_ACT_LSB + 1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // de-emphasis engage and curve; reserved curve code keeps last curve
    // auto engage outranks the bypass bit only while the decoder is
    // on SPDIF with valid status; losing either falls back to the
    // register settings on the next clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emphEnable <= 1'b0;
            emphCurve  <= AFAC_CURVE_32K;
        end else if (emphRamp_q[AFAC_AUTOEMPH_BIT] && spdifActive && csEmphValid) begin
            // (RULE9) follow channel status
            emphEnable <= 1'b1;
            case (csEmphSel)
                2'b00:   emphCurve <= AFAC_CURVE_32K;
                2'b01:   emphCurve <= AFAC_CURVE_44K;
                2'b10:   emphCurve <= AFAC_CURVE_48K;
                default: emphCurve <= emphCurve;
            endcase
        end else begin
            // (RULE10) bypass bit
            emphEnable <= !emphRamp_q[AFAC_BYPASS_BIT];
            // (RULE11) curve select
            case (emphRamp_q[AFAC_CURVE_LSB +: 2])
                2'b00:   emphCurve <= AFAC_CURVE_32K;
                2'b01:   emphCurve <= AFAC_CURVE_44K;
                2'b10:   emphCurve <= AFAC_CURVE_48K;
                default: emphCurve <= emphCurve;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp rate: each sample adds 2^select, one dB step per 512 units
    // the remainder is kept, so slow rates still give evenly spaced
    // steps; an 11-bit sum covers the worst case of 511 plus 128
    assign rampSum = rampAcc_q + (11'h001 << emphRamp_q[AFAC_RATE_LSB +: 3]);

    // soft reset restarts the step spacing from zero
    // (RULE13) volume ramp rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rampAcc_q <= 11'h000;
            rampStep  <= 1'b0;
        end else if (softReset) begin
            rampAcc_q <= 11'h000;
            rampStep  <= 1'b0;
        end else if (sampleTick) begin
            rampStep  <= rampSum >= AFAC_RAMP_DIV;
            rampAcc_q <= (rampSum >= AFAC_RAMP_DIV) ? rampSum - AFAC_RAMP_DIV : rampSum;
        end else begin
            rampStep <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verification/afac_cfg_checker.sv
// assertions on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module afac_cfg_checker
    import afac_pkg::*;
(
    input wire logic        clk,         // clock
    input wire logic        rst,         // async reset
    input wire logic        softReset,   // soft reset
    input wire logic [7:0]  regAddr,     // address
    input wire logic [7:0]  regWrData,   // write byte
    input wire logic        regWrEn,     // write strobe
    input wire logic [7:0]  regRdData,   // read byte
    input wire logic [6:0]  levelDb,     // audio level
    input wire logic        sampleTick,  // sample pulse
    input wire logic [5:0]  wordBits,    // word length
    input wire afac_frame_t frameMode,   // framing
    input wire logic        silenceFlag, // silence
    input wire logic        muteReq,     // mute request
    input wire logic        rampReq,     // ramp request
    input wire logic        rampStep     // volume step
);
    logic [7:0] fmtQ;
    logic [7:0] durQ;
    logic [6:0] thrQ;
    logic [5:0] wbExp;
    // shadow copies of the written registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst || softReset) begin
            fmtQ <= AFAC_RST_FORMAT;
            durQ <= AFAC_RST_DURATION;
            thrQ <= AFAC_RST_THRESHOLD;
        end else if (regWrEn) begin
            if (regAddr == AFAC_OFS_FORMAT) fmtQ <= regWrData;
            if (regAddr == AFAC_OFS_DURATION) durQ <= regWrData;
            if (regAddr == AFAC_OFS_THRESHOLD) thrQ <= regWrData[6:0];
        end
    end
    // expected word length from the shadow
    assign wbExp = (fmtQ[5:4] == 2'b00) ? AFAC_LEN16 : (fmtQ[5:4] == 2'b01) ? AFAC_LEN24 : AFAC_LEN32;
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence wrDur; regWrEn && regAddr == AFAC_OFS_DURATION && !softReset; endsequence
    sequence holdDur; regAddr == AFAC_OFS_DURATION && !softReset; endsequence
    dur_readback_a: assert property (wrDur ##1 holdDur |=> regRdData == $past(regWrData, 2))
        else $error("duration readback wrong");
    thr_top_a: assert property (regAddr == AFAC_OFS_THRESHOLD |=> regRdData[7] == 1'b0)
        else $error("threshold top bit not zero");
    word_len_a: assert property (fmtQ == $past(fmtQ) |-> wordBits == wbExp)
        else $error("word length mismatch");
    frame_sel_a: assert property (fmtQ == $past(fmtQ) |-> frameMode == (fmtQ[1] ? AFAC_FRAME_RIGHT :
        fmtQ[0] ? AFAC_FRAME_LEFT : AFAC_FRAME_I2S)) else $error("framing mismatch");
    soft_defaults_a: assert property (softReset ##1 !regWrEn |=> wordBits == AFAC_LEN32)
        else $error("soft reset default lost");
    zero_dur_a: assert property ((durQ == 8'h00) [*3] |-> !silenceFlag)
        else $error("silence with zero duration");
    loud_clear_a: assert property ((levelDb < thrQ) [*3] |-> !silenceFlag)
        else $error("silence while loud");
    no_cause_a: assert property (!silenceFlag |-> !muteReq && !rampReq)
        else $error("action without silence");
    both_act_a: assert property (silenceFlag && fmtQ[7:6] == 2'b11 && $past(fmtQ[7:6]) == 2'b11
        |-> muteReq && rampReq) else $error("mute and ramp missing");
    step_tick_a: assert property (rampStep |-> $past(sampleTick) ##1 !rampStep)
        else $error("ramp step without tick");
endmodule
`default_nettype wire

// ===== verification/afac_cfg_bank_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module afac_cfg_bank_tb
    import afac_pkg::*;
;
    typedef struct {logic [7:0] d; logic [5:0] wb; logic [5:0] bc; afac_frame_t fm;} afac_row_t;
    logic        clk, rst, softReset, regWrEn, sampleTick, spdifActive, csEmphValid;
    logic [7:0]  regAddr, regWrData, regRdData;
    logic [6:0]  levelDb;
    logic [1:0]  csEmphSel;
    logic [5:0]  wordBits, bclkPerWord;
    afac_frame_t frameMode;
    afac_curve_t emphCurve;
    logic        silenceFlag, muteReq, rampReq, emphEnable, rampStep;
    int          miscompares, n_checks, steps;
    afac_row_t   rows [4] = '{'{8'h1e, AFAC_LEN24, AFAC_LEN32, AFAC_FRAME_RIGHT},
        '{8'h61, AFAC_LEN32, AFAC_LEN16, AFAC_FRAME_LEFT}, '{8'hc4, AFAC_LEN16, AFAC_LEN24, AFAC_FRAME_I2S},
        '{8'h3b, AFAC_LEN32, AFAC_LEN32, AFAC_FRAME_RIGHT}};
    logic [7:0]  rstA [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10};
    logic [7:0]  rstV [6] = '{8'h3c, 8'h00, 8'h00, 8'h68, 8'h4a, 8'h00};

    afac_cfg_bank u_dut (.clk(clk), .rst(rst), .softReset(softReset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .sampleTick(sampleTick),
        .levelDb(levelDb), .spdifActive(spdifActive), .csEmphValid(csEmphValid), .csEmphSel(csEmphSel),
        .wordBits(wordBits), .bclkPerWord(bclkPerWord), .frameMode(frameMode), .silenceFlag(silenceFlag),
        .muteReq(muteReq), .rampReq(rampReq), .emphEnable(emphEnable), .emphCurve(emphCurve),
        .rampStep(rampStep));

    // clock and step counter
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (rampStep === 1'b1) steps++;

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk);
        #2 regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2 regAddr = a;
        @(posedge clk);
        #1 chk("read", regRdData, e);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            #2 sampleTick = 1'b1;
            @(posedge clk);
            #2 sampleTick = 1'b0;
        end
    endtask
    task automatic em(input logic [7:0] d, input logic [3:0] s, input logic e, input afac_curve_t c);
        wr(AFAC_OFS_EMPHRAMP, d);
        {spdifActive, csEmphValid, csEmphSel} = s;
        repeat (2) @(posedge clk);
        #1 chk("emphEnable", emphEnable, e);
        chk("emphCurve", emphCurve, c);
    endtask
    task test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {rst, softReset, regWrEn, sampleTick, spdifActive, csEmphValid} = 6'h21;
        {regAddr, regWrData, csEmphSel, steps} = '0;
        levelDb = 7'd110;
        repeat (8) @(posedge clk);
        #2 rst = 1'b0;
        #1 chk("frameMode", frameMode, AFAC_FRAME_I2S);
        chk("emphEnable", emphEnable, 8'h00);
        foreach (rstA[i]) rd(rstA[i], rstV[i]);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(AFAC_OFS_FORMAT, rows[i].d);
            rd(AFAC_OFS_FORMAT, rows[i].d);
            chk("wordBits", wordBits, rows[i].wb);
            chk("bclkPerWord", bclkPerWord, rows[i].bc);
            chk("frameMode", frameMode, rows[i].fm);
        end
        $display("format rows done");
        wr(AFAC_OFS_RSVD3, 8'hff);
        rd(AFAC_OFS_RSVD3, 8'h00);
        wr(AFAC_OFS_THRESHOLD, 8'hff);
        rd(AFAC_OFS_THRESHOLD, 8'h7f);
        wr(AFAC_OFS_FORMAT, 8'h00);
        @(posedge clk);
        #2 softReset = 1'b1;
        @(posedge clk);
        #2 softReset = 1'b0;
        rd(AFAC_OFS_THRESHOLD, 8'h68);
        rd(AFAC_OFS_FORMAT, 8'h3c);
        chk("wordBits", wordBits, AFAC_LEN32);
        $display("reserved and soft reset done");
        wr(AFAC_OFS_EMPHRAMP, 8'h4f);
        steps = 0;
        ticks(40);
        repeat (2) @(posedge clk);
        #1 chk("rampSteps", steps[7:0], 8'h0a);
        chk("silenceFlag", silenceFlag, 8'h00);
        $display("ramp test done");
        em(8'h18, 4'h0, 1'b1, AFAC_CURVE_44K);
        em(8'h38, 4'h0, 1'b1, AFAC_CURVE_44K);
        em(8'h28, 4'h0, 1'b1, AFAC_CURVE_48K);
        em(8'hc8, 4'he, 1'b1, AFAC_CURVE_48K);
        em(8'hc8, 4'h8, 1'b0, AFAC_CURVE_32K);
        $display("emphasis test done");
        wr(AFAC_OFS_FORMAT, 8'hfc);
        wr(AFAC_OFS_DURATION, 8'hff);
        ticks(8223);
        repeat (2) @(posedge clk);
        #1 chk("silenceFlag", silenceFlag, 8'h00);
        ticks(1);
        repeat (2) @(posedge clk);
        #1 chk("silenceFlag", silenceFlag, 8'h01);
        chk("muteReq", muteReq, 8'h01);
        chk("rampReq", rampReq, 8'h01);
        wr(AFAC_OFS_FORMAT, 8'h7c);
        @(posedge clk);
        #1 chk("muteReq", muteReq, 8'h01);
        chk("rampReq", rampReq, 8'h00);
        wr(AFAC_OFS_FORMAT, 8'hbc);
        @(posedge clk);
        #1 chk("muteReq", muteReq, 8'h00);
        chk("rampReq", rampReq, 8'h01);
        wr(AFAC_OFS_FORMAT, 8'h3c);
        @(posedge clk);
        #1 chk("muteReq", muteReq, 8'h00);
        chk("rampReq", rampReq, 8'h00);
        chk("silenceFlag", silenceFlag, 8'h01);
        #1 levelDb = 7'd20;
        repeat (3) @(posedge clk);
        #1 chk("silenceFlag", silenceFlag, 8'h00);
        $display("silence test done");
        test_done();
    end
    // hang guard
    initial begin
        #3000000;
        miscompares++;
        test_done();
    end
endmodule

bind afac_cfg_bank afac_cfg_checker u_chk (.clk(clk), .rst(rst), .softReset(softReset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .levelDb(levelDb),
    .sampleTick(sampleTick), .wordBits(wordBits), .frameMode(frameMode), .silenceFlag(silenceFlag),
    .muteReq(muteReq), .rampReq(rampReq), .rampStep(rampStep));
`default_nettype wire
